// >>> hdl/sbc_spi_register_map.sv
// Purpose: serial register bank with system summary and mode control
// Assumes: cs_n held low at least 4 clk cycles before first sclk edge and after last
// Notes: sclk domain shifts bits, clk domain owns all registers
`timescale 1ns/100ps

// Behaviour
// R1: frame is address plus control, summary plus status
// R2: exactly eight sampling edges, else frame dropped
// R3: status caught at select fall, write at rise
// R4: summary nibble sent first in every frame
// R5: voltage summary is OR of voltage status
// R6: bus summary is OR of bus status
// R7: high-side summary is OR of high-side status
// R8: low-side summary is OR of low-side status
// R9: even write stores, returns paired odd status
// R10: mode write returns voltage status
// R11: overvoltage shutdown enable gates driver shutdown
// R12: mode bit two stays zero, resets zero
// R13: mode bits select normal, stop, sleep, clear
// R14: status bit three shows supply overvoltage
// R15: status bit two shows supply undervoltage
// R16: status bit one shows regulator overtemperature
// R17: power-on flag set by reset, cleared on mode or voltage access
// R18: timing top bit selects which code stored
// R19: interrupt mask at fourteen, source read back
// R20: analog select and option bits write-only
// R21: snapshot at frame start, clears after frame
module sbc_spi_register_map (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic mosi,
	output logic miso,
	output logic miso_oe,
	input wire logic supply_overvoltage_flag,
	input wire logic supply_undervoltage_flag,
	input wire logic regulator_overtemp_warn,
	input wire logic [3:0] wakeup_status,
	input wire logic [3:0] bus_phy_status,
	input wire logic [3:0] high_side_status,
	input wire logic [3:0] low_side_status,
	input wire logic [3:0] watchdog_state,
	input wire logic [3:0] interrupt_source,
	output sbc_spi_pkg::op_mode_t op_mode,
	output logic watchdog_clear,
	output logic overvoltage_shutdown_enable,
	output logic driver_shutdown,
	output logic power_on_reset_flag,
	output logic [3:0] wakeup_control,
	output logic [3:0] bus_phy_control,
	output logic [3:0] high_side_control,
	output logic [3:0] low_side_control,
	output logic timing_field_select,
	output logic [2:0] watchdog_period_code,
	output logic [2:0] cyclic_sense_period_code,
	output logic input_divider_select,
	output logic [2:0] analog_channel_sel,
	output logic [3:0] option_config,
	output logic [3:0] interrupt_enable_mask,
	output logic frame_error
);
	// reset values of the eight control registers, by pair index
	localparam logic [3:0] CTRL_RST [sbc_spi_pkg::NUM_PAIRS] = '{
		sbc_spi_pkg::RST_MODE_CONTROL, sbc_spi_pkg::RST_WAKEUP_CONTROL,
		sbc_spi_pkg::RST_BUS_PHY_CONTROL, sbc_spi_pkg::RST_HIGH_SIDE_CONTROL,
		sbc_spi_pkg::RST_LOW_SIDE_CONTROL, sbc_spi_pkg::RST_TIMING_CONTROL,
		sbc_spi_pkg::RST_ANALOG_SELECT_CONTROL, sbc_spi_pkg::RST_INTERRUPT_ENABLE_MASK};

	// gray to binary for the edge counter crossing
	function automatic logic [sbc_spi_pkg::CNT_W-1:0] gray2bin(input logic [sbc_spi_pkg::CNT_W-1:0] g);
		logic [sbc_spi_pkg::CNT_W-1:0] b;
		b = '0;
		b[sbc_spi_pkg::CNT_W-1] = g[sbc_spi_pkg::CNT_W-1];
		for (int i = sbc_spi_pkg::CNT_W - 2; i >= 0; i--) begin
			b[i] = b[i+1] ^ g[i];
		end
		return b;
	endfunction

	// link side state (sclk domain)
	logic [sbc_spi_pkg::CNT_W-1:0] link_cnt_q; // free-running falling edge count
	logic [sbc_spi_pkg::CNT_W-1:0] link_gray_q; // gray copy handed to clk
	logic [sbc_spi_pkg::CNT_W-1:0] link_cnt_d;
	logic [7:0] link_rx_q; // mosi shift register, msb first
	logic [3:0] link_addr_q; // address caught after fourth edge
	logic [sbc_spi_pkg::CNT_W-1:0] link_idx; // bit position inside frame
	logic miso_bit;

	// clk side crossing state
	logic cs_meta_q; // first stage, read only by the second
	logic cs_s2_q;
	logic cs_s3_q;
	logic cs_q; // filtered chip select level
	logic cs_fall_ev;
	logic cs_rise_ev;
	logic [sbc_spi_pkg::CNT_W-1:0] gray_meta_q;
	logic [sbc_spi_pkg::CNT_W-1:0] gray_s_q;
	logic [7:0] rx_meta_q;
	logic [7:0] rx_s_q;
	logic [sbc_spi_pkg::CNT_W-1:0] cnt_bin;
	logic [sbc_spi_pkg::CNT_W-1:0] base_q; // edge count at frame start
	logic [sbc_spi_pkg::CNT_W-1:0] frame_len;

	// snapshot and commit state
	logic [3:0] summary_q; // summary nibble of the frame
	logic [3:0] snap_q [sbc_spi_pkg::NUM_PAIRS]; // status nibble per pair
	sbc_spi_pkg::spi_cmd_t cmd_q; // last received frame, accepted or not
	logic commit_q; // one-cycle pulse, frame accepted
	logic [3:0] ctrl_q [sbc_spi_pkg::NUM_PAIRS]; // control registers
	logic [2:0] wd_code_q;
	logic [2:0] cyc_code_q;
	logic [3:0] option_q;
	logic por_flag_q;
	logic wd_clear_q;
	logic frame_err_q;
	sbc_spi_pkg::volt_status_t volt_live;
	logic [3:0] status_live [sbc_spi_pkg::NUM_PAIRS];

	// counter and shifter on the falling sclk edge, the sampling edge
	assign link_cnt_d = link_cnt_q + 6'h01;
	always_ff @(negedge sclk or negedge rst_n) begin
		if (!rst_n) begin
			link_cnt_q <= '0;
			link_gray_q <= '0;
			link_rx_q <= '0;
		end else begin
			link_cnt_q <= link_cnt_d;
			link_gray_q <= link_cnt_d ^ (link_cnt_d >> 1);
			link_rx_q <= {link_rx_q[6:0], mosi}; // see R1
		end
	end

	// address is known after four edges, before the status half goes out
	always_ff @(negedge sclk or negedge rst_n) begin
		if (!rst_n) begin
			link_addr_q <= '0;
		end else if (link_idx == 6'h03) begin
			link_addr_q <= {link_rx_q[2:0], mosi};
		end
	end

	// base_q is frozen for the whole frame, so reading it here is quasi-static
	assign link_idx = link_cnt_q - base_q;

	// summary first, then the status of the addressed pair
	always_comb begin
		miso_bit = 1'b0;
		if (link_idx < 6'h04) begin
			miso_bit = summary_q[2'h3 - link_idx[1:0]]; // see R4
		end else if (link_idx < 6'h08) begin
			miso_bit = snap_q[link_addr_q[3:1]][2'h3 - link_idx[1:0]]; // see R9
		end
	end
	assign miso = miso_bit;
	assign miso_oe = ~cs_n; // driven only while selected

	// chip select: three stages, a change counts once stages two and three agree
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cs_meta_q <= 1'b1;
			cs_s2_q <= 1'b1;
			cs_s3_q <= 1'b1;
			cs_q <= 1'b1;
		end else begin
			cs_meta_q <= cs_n;
			cs_s2_q <= cs_meta_q;
			cs_s3_q <= cs_s2_q;
			if (cs_s2_q == cs_s3_q) begin
				cs_q <= cs_s2_q;
			end
		end
	end
	assign cs_fall_ev = (cs_s2_q == cs_s3_q) && cs_q && !cs_s2_q;
	assign cs_rise_ev = (cs_s2_q == cs_s3_q) && !cs_q && cs_s2_q;

	// edge count and shift data cross as gray word and stopped-clock word
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			gray_meta_q <= '0;
			gray_s_q <= '0;
			rx_meta_q <= '0;
			rx_s_q <= '0;
		end else begin
			gray_meta_q <= link_gray_q;
			gray_s_q <= gray_meta_q;
			rx_meta_q <= link_rx_q;
			rx_s_q <= rx_meta_q;
		end
	end
	assign cnt_bin = gray2bin(gray_s_q);
	assign frame_len = cnt_bin - base_q;

	// live status nibbles by pair index
	assign volt_live = '{supply_overvoltage_flag, supply_undervoltage_flag,
		regulator_overtemp_warn, por_flag_q}; // see R14 see R15 see R16
	assign status_live[0] = volt_live; // see R10
	assign status_live[1] = wakeup_status;
	assign status_live[2] = bus_phy_status;
	assign status_live[3] = high_side_status;
	assign status_live[4] = low_side_status;
	assign status_live[5] = watchdog_state;
	assign status_live[6] = sbc_spi_pkg::RST_STATUS_ZERO; // write-only pair reads zero
	assign status_live[7] = interrupt_source; // see R19

	// frame start: freeze base count, summary and every status nibble
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			base_q <= '0;
			summary_q <= '0;
		end else if (cs_fall_ev) begin
			base_q <= cnt_bin;
			summary_q <= {|volt_live, |bus_phy_status, |high_side_status,
				|low_side_status}; // see R3 see R5 see R6 see R7 see R8 see R21
		end
	end

	// one snapshot entry per pair
	for (genvar p = 0; p < sbc_spi_pkg::NUM_PAIRS; p++) begin : g_snap
		always_ff @(posedge clk) begin
			if (!rst_n) begin
				snap_q[p] <= sbc_spi_pkg::RST_STATUS_ZERO;
			end else if (cs_fall_ev) begin
				snap_q[p] <= status_live[p]; // see R21
			end
		end
	end

	// frame end: accept only an exact eight-edge frame
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cmd_q <= '0;
			commit_q <= 1'b0;
			frame_err_q <= 1'b0;
		end else begin
			commit_q <= cs_rise_ev && (frame_len == sbc_spi_pkg::FRAME_LEN); // see R2 see R3
			frame_err_q <= cs_rise_ev && (frame_len != sbc_spi_pkg::FRAME_LEN); // see R2
			if (cs_rise_ev) begin
				cmd_q <= rx_s_q; // see R1
			end
		end
	end

	// control registers: a write lands only at an even address
	for (genvar p = 0; p < sbc_spi_pkg::NUM_PAIRS; p++) begin : g_ctrl
		always_ff @(posedge clk) begin
			if (!rst_n) begin
				ctrl_q[p] <= CTRL_RST[p];
			end else if (commit_q && !cmd_q.addr[0] && (cmd_q.addr[3:1] == 3'(p))) begin
				ctrl_q[p] <= cmd_q.data; // see R9
				// the mode pair drops its reserved bit so a careless master cannot set it
				if (p == 0) begin
					ctrl_q[p][sbc_spi_pkg::MODE_RSVD_BIT] <= 1'b0; // see R12
				end
			end
		end
	end

	// timing register keeps both codes; the top bit chooses which one loads
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			wd_code_q <= sbc_spi_pkg::RST_PERIOD_CODE;
			cyc_code_q <= sbc_spi_pkg::RST_PERIOD_CODE;
		end else if (commit_q && (cmd_q.addr == sbc_spi_pkg::ADDR_TIMING_CONTROL)) begin
			if (cmd_q.data[sbc_spi_pkg::TIMING_SEL_BIT]) begin
				cyc_code_q <= cmd_q.data[2:0]; // see R18
			end else begin
				wd_code_q <= cmd_q.data[2:0]; // see R18
			end
		end
	end

	// option bits at odd address thirteen, kept apart from the pair array
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			option_q <= sbc_spi_pkg::RST_OPTION_CONFIG;
		end else if (commit_q && (cmd_q.addr == sbc_spi_pkg::ADDR_OPTION_CONFIG)) begin
			option_q <= cmd_q.data; // see R20
		end
	end

	// power-on flag: set by reset, cleared after a valid mode or voltage access
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			por_flag_q <= 1'b1; // see R17
		end else if (commit_q && (cmd_q.addr[3:1] == sbc_spi_pkg::PAIR_MODE)) begin
			por_flag_q <= 1'b0; // see R17 see R21
		end
	end

	// watchdog clear pulse on a mode write with code three
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			wd_clear_q <= 1'b0;
		end else begin
			wd_clear_q <= commit_q && (cmd_q.addr == sbc_spi_pkg::ADDR_MODE_CONTROL) &&
				(cmd_q.data[1:0] == sbc_spi_pkg::MODE_CODE_NORMAL_WDC); // see R13
		end
	end

	// mode decode from the two selector bits
	always_comb begin
		case (ctrl_q[sbc_spi_pkg::PAIR_MODE][1:0]) // see R13
			sbc_spi_pkg::MODE_CODE_STOP: op_mode = sbc_spi_pkg::MODE_STOP;
			sbc_spi_pkg::MODE_CODE_SLEEP: op_mode = sbc_spi_pkg::MODE_SLEEP;
			default: op_mode = sbc_spi_pkg::MODE_NORMAL;
		endcase
	end

	// bit two is never stored, whatever the master sends
	assign overvoltage_shutdown_enable = ctrl_q[sbc_spi_pkg::PAIR_MODE][sbc_spi_pkg::MODE_OVERVOLTAGE_SHUTDOWN_ENABLE_BIT];
	assign driver_shutdown = overvoltage_shutdown_enable && supply_overvoltage_flag; // see R11
	assign watchdog_clear = wd_clear_q;
	assign power_on_reset_flag = por_flag_q;
	assign wakeup_control = ctrl_q[1];
	assign bus_phy_control = ctrl_q[2];
	assign high_side_control = ctrl_q[3];
	assign low_side_control = ctrl_q[4];
	assign timing_field_select = ctrl_q[sbc_spi_pkg::PAIR_TIMING][sbc_spi_pkg::TIMING_SEL_BIT];
	assign watchdog_period_code = wd_code_q;
	assign cyclic_sense_period_code = cyc_code_q;
	assign input_divider_select = ctrl_q[sbc_spi_pkg::PAIR_ANALOG][sbc_spi_pkg::ANALOG_DIV_BIT]; // see R20
	assign analog_channel_sel = ctrl_q[sbc_spi_pkg::PAIR_ANALOG][2:0];
	assign option_config = option_q;
	assign interrupt_enable_mask = ctrl_q[7]; // see R19
	assign frame_error = frame_err_q;

	// reserved mode bit, as stored, reads zero in the register copy
	logic mode_rsvd;
	assign mode_rsvd = ctrl_q[sbc_spi_pkg::PAIR_MODE][sbc_spi_pkg::MODE_RSVD_BIT];

	// checks
	summary_volt_a: assert property (@(posedge clk) disable iff (!rst_n)
		cs_fall_ev |=> summary_q[3] == $past(|volt_live)) else $error("voltage summary wrong"); // see R5
	summary_bus_a: assert property (@(posedge clk) disable iff (!rst_n)
		cs_fall_ev |=> summary_q[2] == $past(|bus_phy_status)) else $error("bus summary wrong"); // see R6
	summary_high_a: assert property (@(posedge clk) disable iff (!rst_n)
		cs_fall_ev |=> summary_q[1] == $past(|high_side_status)) else $error("high-side summary wrong"); // see R7
	summary_low_a: assert property (@(posedge clk) disable iff (!rst_n)
		cs_fall_ev |=> summary_q[0] == $past(|low_side_status)) else $error("low-side summary wrong"); // see R8
	bad_frame_a: assert property (@(posedge clk) disable iff (!rst_n)
		(cs_rise_ev && frame_len != sbc_spi_pkg::FRAME_LEN) |=> !commit_q ##1 $stable(ctrl_q[1]))
		else $error("bad frame committed"); // see R2
	snap_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
		!cs_fall_ev |=> $stable(summary_q)) else $error("summary moved mid-frame"); // see R21
	por_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
		(commit_q && cmd_q.addr[3:1] == sbc_spi_pkg::PAIR_MODE) |=> !por_flag_q)
		else $error("power-on flag not cleared"); // see R17
	mode_rsvd_a: assert property (@(posedge clk) disable iff (!rst_n)
		commit_q |=> !mode_rsvd) else $error("reserved mode bit set"); // see R12
	wd_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
		(commit_q && cmd_q.addr == sbc_spi_pkg::ADDR_MODE_CONTROL && cmd_q.data[1:0] == 2'h3)
		|=> watchdog_clear ##1 !watchdog_clear) else $error("watchdog clear pulse wrong"); // see R13
	shutdown_a: assert property (@(posedge clk) disable iff (!rst_n)
		($rose(supply_overvoltage_flag) && overvoltage_shutdown_enable) |-> driver_shutdown)
		else $error("no shutdown on overvoltage"); // see R11
	good_frame_c: cover property (@(posedge clk) disable iff (!rst_n) commit_q);
	bad_frame_c: cover property (@(posedge clk) disable iff (!rst_n) frame_err_q);
	wd_clear_c: cover property (@(posedge clk) disable iff (!rst_n) watchdog_clear);
	por_clear_c: cover property (@(posedge clk) disable iff (!rst_n) $fell(por_flag_q));
endmodule

// >>> pkg/sbc_spi_pkg.sv
// Purpose: shared constants and types of the serial register bank
// Assumes: 8-bit frames, 4-bit address, 4-bit control and status nibbles
// Notes: control registers sit at even addresses, status at the odd partner, except option bits at odd thirteen
package sbc_spi_pkg;
	// frame geometry
	localparam int FRAME_BITS = 8;
	localparam int HALF_BITS = 4;
	localparam int CNT_W = 6;
	localparam logic [5:0] FRAME_LEN = 6'h08;
	localparam int NUM_PAIRS = 8;

	// register offsets (address A3:A0)
	localparam logic [3:0] ADDR_MODE_CONTROL = 4'h0;
	localparam logic [3:0] ADDR_VOLTAGE_STATUS = 4'h1;
	localparam logic [3:0] ADDR_WAKEUP_CONTROL = 4'h2;
	localparam logic [3:0] ADDR_WAKEUP_STATUS = 4'h3;
	localparam logic [3:0] ADDR_BUS_PHY_CONTROL = 4'h4;
	localparam logic [3:0] ADDR_BUS_PHY_STATUS = 4'h5;
	localparam logic [3:0] ADDR_HIGH_SIDE_CONTROL = 4'h6;
	localparam logic [3:0] ADDR_HIGH_SIDE_STATUS = 4'h7;
	localparam logic [3:0] ADDR_LOW_SIDE_CONTROL = 4'h8;
	localparam logic [3:0] ADDR_LOW_SIDE_STATUS = 4'h9;
	localparam logic [3:0] ADDR_TIMING_CONTROL = 4'ha;
	localparam logic [3:0] ADDR_WATCHDOG_STATE = 4'hb;
	localparam logic [3:0] ADDR_ANALOG_SELECT_CONTROL = 4'hc;
	localparam logic [3:0] ADDR_OPTION_CONFIG = 4'hd;
	localparam logic [3:0] ADDR_INTERRUPT_ENABLE_MASK = 4'he;
	localparam logic [3:0] ADDR_INTERRUPT_SOURCE = 4'hf;

	// pair indices (address bits 3:1)
	localparam logic [2:0] PAIR_MODE = 3'h0;
	localparam logic [2:0] PAIR_TIMING = 3'h5;
	localparam logic [2:0] PAIR_ANALOG = 3'h6;

	// field positions
	localparam int MODE_OVERVOLTAGE_SHUTDOWN_ENABLE_BIT = 3;
	localparam int MODE_RSVD_BIT = 2;
	localparam int TIMING_SEL_BIT = 3;
	localparam int ANALOG_DIV_BIT = 3;

	// mode selector codes
	localparam logic [1:0] MODE_CODE_NORMAL = 2'h0;
	localparam logic [1:0] MODE_CODE_STOP = 2'h1;
	localparam logic [1:0] MODE_CODE_SLEEP = 2'h2;
	localparam logic [1:0] MODE_CODE_NORMAL_WDC = 2'h3;

	// reset values, one per even address, plus option bits, period codes and status nibbles
	localparam logic [3:0] RST_MODE_CONTROL = 4'h8;
	localparam logic [3:0] RST_WAKEUP_CONTROL = 4'hf;
	localparam logic [3:0] RST_BUS_PHY_CONTROL = 4'h0;
	localparam logic [3:0] RST_HIGH_SIDE_CONTROL = 4'h0;
	localparam logic [3:0] RST_LOW_SIDE_CONTROL = 4'h0;
	localparam logic [3:0] RST_TIMING_CONTROL = 4'h0;
	localparam logic [3:0] RST_ANALOG_SELECT_CONTROL = 4'h0;
	localparam logic [3:0] RST_OPTION_CONFIG = 4'h0;
	localparam logic [3:0] RST_INTERRUPT_ENABLE_MASK = 4'h0;
	localparam logic [2:0] RST_PERIOD_CODE = 3'h0;
	localparam logic [3:0] RST_STATUS_ZERO = 4'h0;

	// operating mode, one-hot
	typedef enum logic [2:0] {
		MODE_NORMAL = 3'b001,
		MODE_STOP = 3'b010,
		MODE_SLEEP = 3'b100
	} op_mode_t;

	// received frame: address then control nibble
	typedef struct packed {
		logic [3:0] addr;
		logic [3:0] data;
	} spi_cmd_t;

	// voltage status nibble
	typedef struct packed {
		logic supply_overvoltage_flag;
		logic supply_undervoltage_flag;
		logic regulator_overtemp_warn;
		logic power_on_reset_flag;
	} volt_status_t;
endpackage

// >>> verif/spi_master_model.sv
// Purpose: serial master standing in for the microcontroller on the link
// Assumes: sclk idles low and runs only inside a frame
// Notes: miso is sampled just before each falling edge, where the slave moves on
`timescale 1ns/100ps
module spi_master_model (
	output logic sclk,
	output logic cs_n,
	output logic mosi,
	input wire logic miso
);
	// link idle: clock stopped, select high
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		mosi = 1'b0;
	end

	// one frame; a count other than eight only when a refusal is wanted
	task automatic xfer(input logic [7:0] tx, input int edges, output logic [7:0] rx);
		logic [7:0] sh;
		sh = tx;
		rx = 8'h00;
		cs_n = 1'b0;
		#150; // lead time over four system clocks
		for (int i = 0; i < edges; i++) begin
			sclk = 1'b1;
			mosi = sh[7]; // address first then control, msb first
			sh = {sh[6:0], ~sh[7]};
			#5;
			rx = {rx[6:0], miso}; // summary nibble then status nibble
			#1;
			sclk = 1'b0; // falling edge is the sampling edge
			#6;
		end
		mosi = ~mosi; // stale level must not pass for data
		#150;
		cs_n = 1'b1;
		#300; // commit latency plus the idle gap between frames
	endtask
endmodule

// >>> verif/test_sbc_spi_register_map.sv
// Purpose: self-checking bench for the serial register bank
// Assumes: status inputs change only between frames
// Notes: every valid frame's readback is compared with a model of the snapshot
`timescale 1ns/100ps
module test_sbc_spi_register_map;
	logic clk;
	logic rst_n;
	logic [3:0] st [8]; // status inputs per pair, st[0] top bits are voltage
	logic sclk, cs_n, mosi, miso, miso_oe, miso_last;
	sbc_spi_pkg::op_mode_t op_mode;
	logic watchdog_clear, overvoltage_shutdown_enable, driver_shutdown, power_on_reset_flag;
	logic [3:0] wakeup_control, bus_phy_control, high_side_control, low_side_control;
	logic timing_field_select, input_divider_select, frame_error;
	logic [2:0] watchdog_period_code, cyclic_sense_period_code, analog_channel_sel;
	logic [3:0] option_config, interrupt_enable_mask;
	logic por_exp; // expected power-on flag
	int bad_count, check_count, wdc_n, ferr_n;
	// no pull on the line: a released miso shows the inverse of its last level
	wire logic miso_wire = miso_oe ? miso : ~miso_last;

	always @(miso or miso_oe) if (miso_oe) miso_last = miso;

	// pulse counters for the one-cycle outputs
	always @(posedge clk) begin
		if (watchdog_clear === 1'b1) wdc_n++;
		if (frame_error === 1'b1) ferr_n++;
	end

	sbc_spi_register_map dut_u (
		.clk(clk), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso), .miso_oe(miso_oe),
		.supply_overvoltage_flag(st[0][3]), .supply_undervoltage_flag(st[0][2]),
		.regulator_overtemp_warn(st[0][1]), .wakeup_status(st[1]), .bus_phy_status(st[2]),
		.high_side_status(st[3]), .low_side_status(st[4]), .watchdog_state(st[5]),
		.interrupt_source(st[7]), .op_mode(op_mode), .watchdog_clear(watchdog_clear),
		.overvoltage_shutdown_enable(overvoltage_shutdown_enable), .driver_shutdown(driver_shutdown),
		.power_on_reset_flag(power_on_reset_flag), .wakeup_control(wakeup_control),
		.bus_phy_control(bus_phy_control), .high_side_control(high_side_control),
		.low_side_control(low_side_control), .timing_field_select(timing_field_select),
		.watchdog_period_code(watchdog_period_code), .cyclic_sense_period_code(cyclic_sense_period_code),
		.input_divider_select(input_divider_select), .analog_channel_sel(analog_channel_sel),
		.option_config(option_config), .interrupt_enable_mask(interrupt_enable_mask),
		.frame_error(frame_error)
	);

	spi_master_model master_u (.sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso_wire));

	// 40 MHz system clock
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic complete_run;
		if (bad_count == 0 && check_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// status levels move at the falling clock edge only
	task automatic set_st(input int p, input logic [3:0] v);
		@(negedge clk);
		st[p] = v;
	endtask

	// expected readback: summary of the snapshot then the paired status
	function automatic logic [7:0] exp_rx(input logic [3:0] a);
		logic [3:0] vs;
		logic [3:0] s;
		vs = {st[0][3:1], por_exp};
		case (a[3:1])
			3'h0: s = vs;
			3'h6: s = 4'h0;
			default: s = st[a[3:1]];
		endcase
		return {|vs, |st[2], |st[3], |st[4], s};
	endfunction

	// stored control value behind a writable address
	function automatic logic [3:0] ctrl_out(input logic [3:0] a);
		case (a)
			4'h2: return wakeup_control;
			4'h4: return bus_phy_control;
			4'h6: return high_side_control;
			4'h8: return low_side_control;
			4'hc: return {input_divider_select, analog_channel_sel};
			4'hd: return option_config;
			4'he: return interrupt_enable_mask;
			default: return 4'h0;
		endcase
	endfunction

	task automatic frame(input logic [3:0] a, input logic [3:0] d, input int edges);
		logic [7:0] rx;
		master_u.xfer({a, d}, edges, rx);
		if (edges == 8) begin
			check("readback", rx, exp_rx(a));
			if (a[3:1] == 3'h0) por_exp = 1'b0;
		end
	endtask

	task automatic sc_reset;
		check("hv enable", overvoltage_shutdown_enable, 8'h01);
		check("miso enable", miso_oe, 8'h00);
		check("mode", op_mode, sbc_spi_pkg::MODE_NORMAL);
		check("por flag", power_on_reset_flag, 8'h01);
		check("wakeup ctl", wakeup_control, sbc_spi_pkg::RST_WAKEUP_CONTROL);
	endtask

	// short and long frames change nothing, not even the power-on flag
	task automatic sc_bad_frames;
		frame(4'h4, 4'ha, 7);
		frame(4'h4, 4'ha, 9);
		frame(4'h0, 4'h1, 7);
		check("bus ctl", bus_phy_control, 8'h00);
		check("mode", op_mode, sbc_spi_pkg::MODE_NORMAL);
		check("por flag", power_on_reset_flag, 8'h01);
		check("frame errors", 8'(ferr_n), 8'h03);
	endtask

	task automatic sc_power_flag;
		frame(4'h3, 4'h0, 8);
		check("por kept", power_on_reset_flag, 8'h01);
		frame(4'h1, 4'h0, 8);
		check("por cleared", power_on_reset_flag, 8'h00);
	endtask

	// each summary bit sees both zero and nonzero sources
	task automatic sc_summary;
		for (int k = 0; k < 3; k++) begin
			set_st(0, 4'(k * 2));
			for (int p = 1; p < 8; p++) set_st(p, ((p + k) % 3 == 0) ? 4'h0 : 4'(1 << ((p + k) % 4)));
			for (int p = 0; p < 8; p++) frame(4'(2 * p + 1), 4'h0, 8);
		end
	endtask

	task automatic sc_mode;
		int n;
		set_st(0, 4'h8); // supply overvoltage present
		for (int c = 0; c < 4; c++) begin
			n = wdc_n;
			frame(4'h0, {c[0], 1'b0, c[1:0]}, 8); // bit two always written zero
			check("mode", op_mode, (c == 1) ? 3'b010 : (c == 2) ? 3'b100 : 3'b001);
			check("wd clear", 8'(wdc_n - n), (c == 3) ? 8'h01 : 8'h00);
			check("hv enable", overvoltage_shutdown_enable, 8'(c % 2));
			check("shutdown", driver_shutdown, 8'(c % 2));
		end
	endtask

	task automatic sc_controls;
		logic [7:0] tab [8];
		tab = '{8'h25, 8'h49, 8'h66, 8'h83, 8'hcb, 8'hd7, 8'hed, 8'h3f};
		for (int i = 0; i < 8; i++) frame(tab[i][7:4], tab[i][3:0], 8);
		for (int i = 0; i < 7; i++) check("control", ctrl_out(tab[i][7:4]), tab[i][3:0]);
	endtask

	task automatic sc_timing;
		frame(4'ha, 4'h5, 8);
		frame(4'ha, 4'hb, 8);
		check("wd code", watchdog_period_code, 8'h05);
		check("cs code", cyclic_sense_period_code, 8'h03);
		check("select", timing_field_select, 8'h01);
	endtask

	initial begin
		bad_count = 0;
		check_count = 0;
		wdc_n = 0;
		ferr_n = 0;
		miso_last = 1'b0;
		por_exp = 1'b1;
		for (int p = 0; p < 8; p++) st[p] = 4'h0;
		rst_n = 1'b0;
		repeat (2) @(negedge clk); // two clock cycles of reset
		rst_n = 1'b1;
		repeat (4) @(negedge clk);
		sc_reset();
		sc_bad_frames();
		sc_power_flag();
		sc_summary();
		sc_mode();
		sc_controls();
		sc_timing();
		complete_run();
	end

	// hang guard
	initial begin
		#200000;
		bad_count++;
		complete_run();
	end
endmodule
